// ==== rtl/dcm_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - with serial config selected, power-down follows the config bit, pin ignored
// - config power-down bit resets low, so device starts powered down
// - channel zero: blue during active video, hsync and vsync during blanking
// - channel one: green during active video, control bit one during blanking
// - channel two: red during active video, control bits three and two in blanking
// - a separate link clock pair is driven beside the three data channels
// - config deselected: pin high means normal operation, low means power-down
// - in power-down link outputs and core stop, config logic stays alive
// - select low then high resets config state and restores register defaults
//////////////////////////////////////////////////////////////////////////////
package dcm_pkg;

    localparam int DCM_COMPONENT_WIDTH = 8;
    localparam logic DCM_CFG_POWER_DOWN_N_RESET = 1'b0;
    localparam int DCM_CTL_LO = 1;
    localparam int DCM_CTL_HI = 3;

    typedef enum logic {
        DCM_PWR_DOWN = 1'b0,
        DCM_PWR_ON = 1'b1
    } dcm_power_e;

    // pixel and sync information from the graphics controller
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic de;
        logic hsync;
        logic vsync;
        logic [DCM_CTL_HI:DCM_CTL_LO] blanking_control_bits;
    } dcm_pixel_s;

    // symbol content of the three link channels
    typedef struct packed {
        logic [7:0] link_channel_two;
        logic [7:0] link_channel_one;
        logic [7:0] link_channel_zero;
        logic de;
    } dcm_link_s;

    localparam dcm_link_s DCM_LINK_IDLE = '0;

endpackage : dcm_pkg

// ==== rtl/dcm_top.sv ====
`timescale 1ns/1ps
module dcm_top
    import dcm_pkg::*;
#(
    parameter int COMPONENT_WIDTH = DCM_COMPONENT_WIDTH
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // graphics controller side
    input wire logic pixel_clock_in,
    input wire dcm_pixel_s pixel_in,
    // power and configuration pins
    input wire logic power_down_n_in,
    input wire logic serial_config_select_in,
    // configuration register write, from serial config logic on clk_sys_in
    input wire logic cfg_write_in,
    input wire logic cfg_power_down_n_in,
    // link side
    output dcm_link_s link_out,
    output logic link_clock_pair_p_out,
    output logic link_clock_pair_n_out,
    output logic powered_up_out
);

    if (COMPONENT_WIDTH != 8) begin : g_bad_width
        $error("dcm_top supports only 8-bit components");
    end

    //////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic pclk_s1;
    logic pclk_s2;
    logic pclk_prev;
    dcm_pixel_s pix_s1;
    dcm_pixel_s pix_s2;
    logic pd_s1;
    logic pd_s2;
    logic sel_s1;
    logic sel_s2;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pclk_s1 <= 1'b0;
            pclk_s2 <= 1'b0;
            pclk_prev <= 1'b0;
            pix_s1 <= '0;
            pix_s2 <= '0;
            pd_s1 <= 1'b0;
            pd_s2 <= 1'b0;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end else begin
            pclk_s1 <= pixel_clock_in;
            pclk_s2 <= pclk_s1;
            pclk_prev <= pclk_s2;
            pix_s1 <= pixel_in;
            pix_s2 <= pix_s1;
            pd_s1 <= power_down_n_in;
            pd_s2 <= pd_s1;
            sel_s1 <= serial_config_select_in;
            sel_s2 <= sel_s1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // configuration power-down bit
    logic cfg_power_down_n;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_power_down_n <= DCM_CFG_POWER_DOWN_N_RESET;
        end else if (!sel_s2) begin
            cfg_power_down_n <= DCM_CFG_POWER_DOWN_N_RESET;
        end else if (cfg_write_in) begin
            cfg_power_down_n <= cfg_power_down_n_in;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // power state
    dcm_power_e power_state;
    dcm_power_e next_power_state;
    wire logic power_request_n = sel_s2 ? cfg_power_down_n : pd_s2;

    always_comb begin
        case (power_request_n)
            1'b1: next_power_state = DCM_PWR_ON;
            1'b0: next_power_state = DCM_PWR_DOWN;
            default: next_power_state = DCM_PWR_DOWN;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            power_state <= DCM_PWR_DOWN;
        end else begin
            power_state <= next_power_state;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // channel mapping
    function automatic dcm_link_s dcm_map(input dcm_pixel_s p);
        dcm_link_s l;
        l.de = p.de;
        if (p.de) begin
            l.link_channel_zero = p.blue;
            l.link_channel_one = p.green;
            l.link_channel_two = p.red;
        end else begin
            l.link_channel_zero = {6'h00, p.vsync, p.hsync};
            l.link_channel_one = {7'h00, p.blanking_control_bits[1]};
            l.link_channel_two = {6'h00, p.blanking_control_bits[3:2]};
        end
        return l;
    endfunction : dcm_map

    wire logic pixel_rise = pclk_s2 & ~pclk_prev;
    wire logic is_on = (power_state == DCM_PWR_ON);
    wire dcm_link_s mapped_link = dcm_map(pix_s2);

    //////////////////////////////////////////////////////////////////////////
    // link outputs
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link_out <= DCM_LINK_IDLE;
            link_clock_pair_p_out <= 1'b0;
            link_clock_pair_n_out <= 1'b0;
            powered_up_out <= 1'b0;
        end else begin
            powered_up_out <= is_on;
            if (!is_on) begin
                link_out <= DCM_LINK_IDLE;
            end else if (pixel_rise) begin
                link_out <= mapped_link;
            end
            link_clock_pair_p_out <= is_on & pclk_s2;
            link_clock_pair_n_out <= is_on & ~pclk_s2;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking dcm_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_CFG_OVERRIDES_PIN: assert property (
        (sel_s2 && !cfg_power_down_n && pd_s2) |=> (power_state == DCM_PWR_DOWN))
        else $error("config bit did not override power-down pin");

    AST_CFG_DEFAULT_LOW: assert property (
        $rose(sel_s2) |-> !cfg_power_down_n)
        else $error("config power-down bit not at default on select");

    AST_CFG_RESET_BY_SELECT: assert property (
        (!sel_s2 ##1 sel_s2) |=> (power_state == DCM_PWR_DOWN) ##1 !powered_up_out)
        else $error("select toggle did not restore power-down default");

    AST_PIN_HIGH_ON: assert property (
        (!sel_s2 && pd_s2) |=> is_on ##1 powered_up_out)
        else $error("pin high did not power up");

    AST_PIN_LOW_DOWN: assert property (
        (!sel_s2 && !pd_s2) |=> !is_on)
        else $error("pin low did not power down");

    AST_CH0_MAP: assert property (
        (pixel_rise && is_on) |=> link_out.link_channel_zero == ($past(pix_s2.de) ?
            $past(pix_s2.blue) : {6'h00, $past(pix_s2.vsync), $past(pix_s2.hsync)}))
        else $error("channel zero content wrong");

    AST_CH1_MAP: assert property (
        (pixel_rise && is_on) |=> link_out.link_channel_one == ($past(pix_s2.de) ?
            $past(pix_s2.green) : {7'h00, $past(pix_s2.blanking_control_bits[1])}))
        else $error("channel one content wrong");

    AST_CH2_MAP: assert property (
        (pixel_rise && is_on) |=> link_out.link_channel_two == ($past(pix_s2.de) ?
            $past(pix_s2.red) : {6'h00, $past(pix_s2.blanking_control_bits[3:2])}))
        else $error("channel two content wrong");

    AST_DOWN_SILENT: assert property (
        !is_on |=> (link_out == DCM_LINK_IDLE) && !link_clock_pair_p_out
            && !link_clock_pair_n_out)
        else $error("link active during power-down");

    AST_LINK_CLOCK: assert property (
        is_on |=> (link_clock_pair_p_out == $past(pclk_s2))
            && (link_clock_pair_n_out != link_clock_pair_p_out))
        else $error("link clock pair wrong");

    AST_PIN_IGNORED: assert property (
        (sel_s2 && cfg_power_down_n && !pd_s2) |=> is_on)
        else $error("power-down pin not ignored while config selected");

    AST_CFG_WRITE_TAKEN: assert property (
        (sel_s2 && cfg_write_in) |=> (cfg_power_down_n == $past(cfg_power_down_n_in)))
        else $error("config power-down write not taken");

    AST_CFG_CLEARED: assert property (
        !sel_s2 |=> !cfg_power_down_n)
        else $error("config bit not cleared while deselected");

    AST_DE_MAP: assert property (
        (pixel_rise && is_on) |=> (link_out.de == $past(pix_s2.de)))
        else $error("data enable marker wrong on link");

    AST_LINK_HOLDS: assert property (
        (is_on && !pixel_rise) |=> $stable(link_out))
        else $error("link symbols changed between pixel clock edges");

    AST_POWERED_FOLLOWS: assert property (
        powered_up_out == $past(is_on))
        else $error("powered indication does not follow power state");

    COV_POWER_UP: cover property (!is_on ##1 is_on);
    COV_SEL_TOGGLE: cover property (!sel_s2 ##1 sel_s2);
    COV_ACTIVE: cover property (pixel_rise && is_on && pix_s2.de);
    COV_BLANK: cover property (pixel_rise && is_on && !pix_s2.de);
    COV_CFG_ON: cover property (sel_s2 && cfg_power_down_n && is_on);

endmodule : dcm_top

// ==== sim/dcm_rx_model.sv ====
`timescale 1ns/1ps
// display receiver: takes one symbol set per rising edge of the link clock pair
module dcm_rx_model
    import dcm_pkg::*;
(
    // clock
    input wire logic clk_sys_in,
    // link side
    input wire dcm_link_s link_in,
    input wire logic clk_p_in,
    input wire logic clk_n_in,
    // captured symbols
    output dcm_link_s sym_out,
    output logic [15:0] sym_count_out
);
    logic p_last = 1'b0;
    dcm_link_s sym = '0;
    logic [15:0] sym_count = 16'h0000;
    assign sym_out = sym;
    assign sym_count_out = sym_count;
    always @(posedge clk_sys_in) begin
        p_last <= clk_p_in;
        if (clk_p_in && !p_last && !clk_n_in) begin
            sym <= link_in;
            sym_count <= sym_count + 16'h0001;
        end
    end
endmodule : dcm_rx_model

// ==== sim/dcm_top_tb_top.sv ====
`timescale 1ns/1ps
module dcm_top_tb_top
    import dcm_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic pclk = 1'b0;
    dcm_pixel_s pixel = '0;
    logic pin_n = 1'b1;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic wr_d = 1'b0;
    dcm_link_s link, rx_sym;
    logic clk_p, clk_n, pwr;
    logic [15:0] rx_count;
    int fails = 0;
    int n_checks = 0;
    logic [15:0] cnt0 = 16'h0000;
    // one row: pixel input and the link symbol set it should give
    typedef struct packed {
        dcm_pixel_s pix;
        dcm_link_s want;
    } dcm_row_s;
    localparam dcm_row_s ROWS [4] = '{
        '{'{8'ha5, 8'h3c, 8'h81, 1'b1, 1'b0, 1'b1, 3'h0}, '{8'ha5, 8'h3c, 8'h81, 1'b1}},
        '{'{8'hff, 8'hff, 8'hff, 1'b0, 1'b1, 1'b0, 3'h5}, '{8'h02, 8'h01, 8'h01, 1'b0}},
        '{'{8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 3'h2}, '{8'h01, 8'h00, 8'h02, 1'b0}},
        '{'{8'h00, 8'hff, 8'h7e, 1'b1, 1'b1, 1'b1, 3'h7}, '{8'h00, 8'hff, 8'h7e, 1'b1}}};
    always #5 clk_sys_in = ~clk_sys_in;
    initial #3 forever #62.5 pclk = ~pclk;
    dcm_top dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .pixel_clock_in(pclk),
        .pixel_in(pixel), .power_down_n_in(pin_n), .serial_config_select_in(sel),
        .cfg_write_in(wr), .cfg_power_down_n_in(wr_d), .link_out(link),
        .link_clock_pair_p_out(clk_p), .link_clock_pair_n_out(clk_n), .powered_up_out(pwr));
    dcm_rx_model rx_u (.clk_sys_in(clk_sys_in), .link_in(link), .clk_p_in(clk_p),
        .clk_n_in(clk_n), .sym_out(rx_sym), .sym_count_out(rx_count));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [24:0] e, input logic [24:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : tick
    task automatic wait_pwr(input logic v);
        for (int i = 0; i < 20 && pwr !== v; i++) tick(1);
        chk("powered_up", v, pwr);
    endtask : wait_pwr
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    initial begin
        tick(10);
        chk("reset link", 25'h0, link);
        chk("reset outputs", 25'h0, {clk_p, clk_n, pwr});
        tick(6);
        reset_n_in = 1'b1;
        wait_pwr(1'b1);
        for (int r = 0; r < 4; r++) begin
            @(negedge pclk);
            tick(1);
            pixel = ROWS[r].pix;
            cnt0 = rx_count;
            tick(4);
            chk("clock pair low", 25'h1, {clk_p, clk_n});
            @(posedge pclk);
            tick(5);
            chk("link", ROWS[r].want, link);
            chk("clock pair", 25'h2, {clk_p, clk_n});
            tick(3);
            chk("rx symbol", ROWS[r].want, rx_sym);
            chk("rx count", cnt0 + 16'h0001, rx_count);
        end
        pin_n = 1'b0;
        wait_pwr(1'b0);
        tick(3);
        cnt0 = rx_count;
        chk("down link", 25'h0, link);
        chk("down clocks", 25'h0, {clk_p, clk_n});
        tick(40);
        chk("down rx count", cnt0, rx_count);
        chk("down link held", 25'h0, link);
        sel = 1'b1;
        pin_n = 1'b1;
        tick(10);
        chk("cfg default", 1'b0, pwr);
        wr_d = 1'b1;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        wait_pwr(1'b1);
        pin_n = 1'b0;
        tick(8);
        chk("pin ignored", 1'b1, pwr);
        pin_n = 1'b1;
        sel = 1'b0;
        tick(8);
        chk("pin mode", 1'b1, pwr);
        sel = 1'b1;
        wait_pwr(1'b0);
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        wait_pwr(1'b1);
        reset_n_in = 1'b0;
        tick(2);
        chk("mid reset link", 25'h0, link);
        chk("mid reset outputs", 25'h0, {clk_p, clk_n, pwr});
        reset_n_in = 1'b1;
        tick(12);
        chk("restart down", 1'b0, pwr);
        chk("restart clocks", 25'h0, {clk_p, clk_n});
        end_sim();
    end
endmodule : dcm_top_tb_top
